// ===== design/channel_knob_mode_control.sv
/*
  Channel select, volume/gain knob modes, mute, ring display and the timed
  auto-gain sequence of the mixer front panel.
  Assumes pins (buttons, switch, encoder) are asynchronous, clip and
  auto-gain level come from the audio datapath on ref_clk_in.
*/
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module channel_knob_mode_control #(
  parameter int NCH            = knob_pkg::NCH_DEF,
  parameter int GAIN_IDLE_CYC  = knob_pkg::GAIN_IDLE_CYC,
  parameter int HOLD_CYC       = knob_pkg::HOLD_CYC,
  parameter int LISTEN_CYC     = knob_pkg::LISTEN_CYC,
  parameter int DTAP_CYC       = knob_pkg::DTAP_CYC,
  parameter int SHOW_CYC       = knob_pkg::SHOW_CYC,
  parameter int FLASH_SLOW_CYC = knob_pkg::FLASH_SLOW_CYC,
  parameter int FLASH_FAST_CYC = knob_pkg::FLASH_FAST_CYC
) (
  input  wire logic                         ref_clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         ce_in,
  input  wire logic [NCH-1:0]               chan_btn_in,
  input  wire logic                         knob_sw_in,
  input  wire logic                         enc_a_in,
  input  wire logic                         enc_b_in,
  input  wire logic [NCH-1:0]               clip_in,
  input  wire logic [knob_pkg::LVL_W-1:0]   agc_gain_in,
  input  wire logic [knob_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [31:0]                  wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [31:0]                  rdata_out,
  output logic      [NCH-1:0]               chan_led_out,
  output logic      [$clog2(NCH)-1:0]       sel_chan_out,
  output logic                              recall_out,
  output logic      [NCH*knob_pkg::LVL_W-1:0] vol_all_out,
  output logic      [NCH*knob_pkg::LVL_W-1:0] gain_all_out,
  output logic      [NCH-1:0]               mute_out,
  output logic                              agc_listen_out,
  output logic      [knob_pkg::RING_N-1:0]  ring_on_out,
  output logic                              ring_white_out,
  output logic                              overload_red_out,
  output logic                              gain_ind_out,
  output logic                              vol_green_out,
  output logic                              vol_red_out
);
  import knob_pkg::*;

  localparam int SEL_W = $clog2(NCH);
  localparam int SN    = NCH + 3;              // synced pin count

  // logic serves 2..8 channels and counts inside the timer
  if (NCH < 2 || NCH > 8)
    $error("channel_knob_mode_control: NCH must be 2..8");
  if (GAIN_IDLE_CYC < 1 || LISTEN_CYC < 1 || SHOW_CYC < 1 || FLASH_SLOW_CYC < 1 || FLASH_FAST_CYC < 1
      || LISTEN_CYC >= (1 << TMR_W) || GAIN_IDLE_CYC >= (1 << TMR_W))
    $error("channel_knob_mode_control: timing out of range");

  localparam logic [TMR_W-1:0] GAIN_LIM   = TMR_W'(GAIN_IDLE_CYC - 1);
  localparam logic [TMR_W-1:0] LISTEN_LIM = TMR_W'(LISTEN_CYC - 1);
  localparam logic [TMR_W-1:0] SHOW_LIM   = TMR_W'(SHOW_CYC - 1);
  localparam logic [TMR_W-1:0] FSLOW_LIM  = TMR_W'(FLASH_SLOW_CYC - 1);
  localparam logic [TMR_W-1:0] FFAST_LIM  = TMR_W'(FLASH_FAST_CYC - 1);

  typedef enum logic [2:0] {S_VOL, S_GAIN, S_LISTEN, S_SHOW, S_FSLOW, S_FFAST} knob_st_t;

  typedef struct packed {
    knob_st_t                   st;       // knob mode
    logic [SN-1:0]              s1;       // sync stage 1, read by s2 only
    logic [SN-1:0]              s2;       // sync stage 2
    logic [SN-1:0]              s3;       // previous, for edges
    logic [SEL_W-1:0]           sel;      // selected channel
    logic [NCH-1:0][LVL_W-1:0]  vol;      // stored volumes
    logic [NCH-1:0][LVL_W-1:0]  gain;     // stored gains
    logic [NCH-1:0]             mute;     // per-channel mute
    logic [NCH-1:0]             agcv;     // gain set by auto-gain
    logic [TMR_W-1:0]           tmr;      // mode timer
    logic [BLINK_W-1:0]         blink;    // free blink counter
    logic [NCH-1:0]             chan_led; // channel indicators
    logic                       recall;   // settings recall pulse
    logic [RING_N-1:0]          ring;     // ring led on
    logic                       white;    // ring colour white
    logic                       ol_red;   // ninth led red
    logic                       gain_ind; // gain indicator
    logic                       vol_g;    // volume indicator green
    logic                       vol_r;    // volume indicator red
    logic [31:0]                rdata;    // read data
  } state_t;

  state_t q, n;

  logic tap1, tap2, hold;                 // gesture pulses
  logic [NCH-1:0] btn_rise;               // new button presses
  logic step_up, step_dn;                 // encoder detents
  logic mute_sel;                         // selected channel muted
  logic vg_mode;                          // volume or gain mode

  assign btn_rise = q.s2[NCH-1:0] & ~q.s3[NCH-1:0];
  // quadrature: a rising edge of A, direction from B
  assign step_up  = q.s2[NCH+1] & ~q.s3[NCH+1] & ~q.s2[NCH+2];
  assign step_dn  = q.s2[NCH+1] & ~q.s3[NCH+1] & q.s2[NCH+2];
  assign mute_sel = q.mute[q.sel];
  assign vg_mode  = (q.st == S_VOL) || (q.st == S_GAIN);

  // press classifier on the synced switch level
  knob_gesture #(
    .HOLD_CYC (HOLD_CYC),
    .DTAP_CYC (DTAP_CYC)
  ) u_gesture (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .press_in   (q.s2[NCH]),
    .tap1_out   (tap1),
    .tap2_out   (tap2),
    .hold_out   (hold)
  );

  // saturating one-detent level step
  function automatic logic [LVL_W-1:0] lvl_step(input logic [LVL_W-1:0] l, input logic up, input logic dn);
    lvl_step = l;
    if (up && l < LVL_MAX) begin
      lvl_step = l + 1'b1;
    end else if (dn && l != '0) begin
      lvl_step = l - 1'b1;
    end
  endfunction

  // first `l` ring leds lit
  function automatic logic [RING_N-1:0] lvl_mask(input logic [LVL_W-1:0] l);
    for (int i = 0; i < RING_N; i++) begin
      lvl_mask[i] = (i < int'(l));
    end
  endfunction

  // next state: pins, modes, sequence, display, register port
  always_comb begin
    logic [LVL_W-1:0]  lvl;
    logic [RING_N-1:0] mask;
    logic              slow, fast, found;
    lvl   = '0;
    mask  = '0;
    slow  = 1'b0;
    fast  = 1'b0;
    found = 1'b0;
    n = q;
    n.recall = 1'b0;
    if (ce_in) begin
      n.s1    = {enc_b_in, enc_a_in, knob_sw_in, chan_btn_in};
      n.s2    = q.s1;
      n.s3    = q.s2;
      n.blink = q.blink + 1'b1;
      n.tmr   = q.tmr + 1'b1;
      case (q.st)
        S_VOL, S_GAIN: begin
          if (hold) begin
            // works from either mode, any channel, repeatable
            n.st   = S_LISTEN;
            n.tmr  = '0;
          end else if ((tap1 || tap2) && mute_sel) begin
            n.mute[q.sel] = 1'b0;
            n.tmr = '0;
          end else if (tap2) begin
            n.mute[q.sel] = 1'b1;
            n.tmr = '0;
          end else if (tap1) begin
            n.st  = (q.st == S_VOL) ? S_GAIN : S_VOL;
            n.tmr = '0;
          end else if (q.st == S_VOL) begin
            n.vol[q.sel] = lvl_step(q.vol[q.sel], step_up, step_dn);
          end else if (step_up || step_dn) begin
            n.gain[q.sel] = lvl_step(q.gain[q.sel], step_up, step_dn);
            n.agcv[q.sel] = 1'b0;
            n.tmr = '0;
          end else if (q.tmr >= GAIN_LIM) begin
            n.st = S_VOL;
          end
          // a new selection drops gain mode and recalls settings
          if (btn_rise != '0 && !hold) begin
            for (int i = 0; i < NCH; i++) begin
              if (btn_rise[i] && !found) begin
                n.sel = SEL_W'(i);
                found = 1'b1;
              end
            end
            n.st     = S_VOL;
            n.recall = 1'b1;
          end
        end
        S_LISTEN: begin
          // rotation is not read here at all
          if (agc_gain_in <= LVL_MAX) begin
            n.gain[q.sel] = agc_gain_in;
          end
          if (hold) begin
            n.tmr = '0;
          end else if (q.tmr >= LISTEN_LIM) begin
            n.st = S_SHOW;
            n.tmr = '0;
            n.agcv[q.sel] = 1'b1;
          end
        end
        S_SHOW: begin
          if (q.tmr >= SHOW_LIM) begin
            n.st  = S_FSLOW;
            n.tmr = '0;
          end
        end
        S_FSLOW: begin
          if (q.tmr >= FSLOW_LIM) begin
            n.st  = S_FFAST;
            n.tmr = '0;
          end
        end
        S_FFAST: begin
          if (q.tmr >= FFAST_LIM) begin
            n.st  = S_VOL;
            n.tmr = '0;
          end
        end
        default: n.st = S_VOL;
      endcase
      // software apply-defaults wins over knob edits this cycle
      if (wr_in && addr_in == REG_CTRL && wdata_in[CTRL_DEF_BIT]) begin
        n.vol  = {NCH{LVL_DEF}};
        n.gain = {NCH{LVL_DEF}};
        n.mute = '0;
        n.agcv = '0;
        n.st   = S_VOL;
      end
      // display, from the current state
      slow = q.blink[SLOW_BIT];
      fast = q.blink[FAST_BIT];
      lvl  = (q.st == S_VOL) ? q.vol[q.sel] : q.gain[q.sel];
      mask = lvl_mask(lvl);
      n.chan_led = '0;
      n.chan_led[q.sel] = 1'b1;
      n.white    = (q.st != S_VOL);
      n.gain_ind = (q.st != S_VOL);
      n.vol_g    = (q.st == S_VOL) && !mute_sel;
      n.vol_r    = mute_sel;
      n.ol_red   = 1'b0;
      case (q.st)
        S_VOL, S_GAIN: begin
          // muted rings flash in the mode colour
          n.ring = (mute_sel && !slow) ? '0 : mask;
          if (clip_in[q.sel]) begin
            n.ring[RING_N-1] = 1'b1;
            n.ol_red = 1'b1;
          end
        end
        S_LISTEN: n.ring = slow ? mask : '0;
        S_SHOW:   n.ring = mask;
        S_FSLOW:  n.ring = slow ? '1 : '0;
        S_FFAST:  n.ring = fast ? '1 : '0;
        default:  n.ring = '0;
      endcase
      // register reads answer the next cycle
      n.rdata = '0;
      if (rd_in && addr_in == REG_STATUS) begin
        n.rdata[2:0] = 3'(q.sel);
        n.rdata[6:4] = q.st;
        n.rdata[8]   = mute_sel;
        n.rdata[9]   = q.agcv[q.sel];
      end
    end
  end

  // state register; reset applies defaults, channel 1 selected
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q          <= '0;
      q.vol      <= {NCH{LVL_DEF}};
      q.gain     <= {NCH{LVL_DEF}};
      q.chan_led <= NCH'(1);
    end else begin
      q <= n;
    end
  end

  assign rdata_out        = q.rdata;
  assign chan_led_out     = q.chan_led;
  assign sel_chan_out     = q.sel;
  assign recall_out       = q.recall;
  assign vol_all_out      = q.vol;
  assign gain_all_out     = q.gain;
  assign mute_out         = q.mute;
  assign agc_listen_out   = (q.st == S_LISTEN);
  assign ring_on_out      = q.ring;
  assign ring_white_out   = q.white;
  assign overload_red_out = q.ol_red;
  assign gain_ind_out     = q.gain_ind;
  assign vol_green_out    = q.vol_g;
  assign vol_red_out      = q.vol_r;

  // checks on the mode logic
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_onehot_led;
    $onehot(chan_led_out);
  endproperty
  a_onehot_led: assert property (p_onehot_led) else $error("channel leds not one-hot");

  property p_recall;
    ce_in && vg_mode && btn_rise != '0 && !hold |=> recall_out && q.st == S_VOL;
  endproperty
  a_recall: assert property (p_recall) else $error("selection without recall");

  property p_tap_gain;
    ce_in && q.st == S_VOL && tap1 && !mute_sel && btn_rise == '0 && !wr_in |=> q.st == S_GAIN;
  endproperty
  a_tap_gain: assert property (p_tap_gain) else $error("tap did not enter gain mode");

  property p_gain_ind;
    ce_in && q.st == S_GAIN |=> gain_ind_out && ring_white_out && !vol_green_out;
  endproperty
  a_gain_ind: assert property (p_gain_ind) else $error("gain mode indicators wrong");

  property p_gain_idle;
    q.st == S_GAIN |-> q.tmr <= GAIN_LIM;
  endproperty
  a_gain_idle: assert property (p_gain_idle) else $error("gain mode outlived idle time");

  property p_clip_red;
    ce_in && vg_mode && clip_in[q.sel] |=> overload_red_out && ring_on_out[RING_N-1];
  endproperty
  a_clip_red: assert property (p_clip_red) else $error("clip not shown red");

  property p_hold_listen;
    ce_in && vg_mode && hold && !wr_in |=> q.st == S_LISTEN && q.tmr == '0;
  endproperty
  a_hold_listen: assert property (p_hold_listen) else $error("hold did not start listening");

  property p_listen_track;
    ce_in && q.st == S_LISTEN && agc_gain_in <= LVL_MAX && !wr_in |=> q.gain[q.sel] == $past(agc_gain_in);
  endproperty
  a_listen_track: assert property (p_listen_track) else $error("gain not tracking auto-gain");

  property p_listen_len;
    q.st == S_LISTEN |-> q.tmr <= LISTEN_LIM;
  endproperty
  a_listen_len: assert property (p_listen_len) else $error("listening too long");

  property p_manual_clear;
    ce_in && q.st == S_GAIN && (step_up || step_dn) && !hold && !tap1 && !tap2 && !wr_in
      |=> !q.agcv[$past(q.sel)];
  endproperty
  a_manual_clear: assert property (p_manual_clear) else $error("auto-gain result kept");

  c_gain: cover property (q.st == S_GAIN);
  c_mute: cover property (vol_red_out);
  c_done: cover property (q.st == S_FFAST ##1 q.st == S_VOL);
endmodule
`default_nettype wire

// ===== design/knob_pkg.sv
/*
  Shared constants for the channel knob control block: clock rate, gesture
  and sequence times, display levels, blink rates and register offsets.
  Assumes a single system clock at CLK_HZ; every time is in milliseconds.
*/
package knob_pkg;
  localparam int CLK_HZ      = 25_000_000;           // system clock rate
  localparam int CYC_PER_MS  = CLK_HZ / 1000;        // cycles per millisecond
  localparam int NCH_DEF     = 5;                    // channels 1..4 and 5/6
  // times as specified, in ms
  localparam int GAIN_IDLE_MS   = 5000;              // gain mode inactivity
  localparam int HOLD_MS        = 2000;              // press-and-hold
  localparam int LISTEN_MS      = 10000;             // auto-gain listening
  localparam int DTAP_MS        = 300;               // double tap window
  localparam int SHOW_MS        = 500;               // final position shown
  localparam int FLASH_SLOW_MS  = 1500;              // slow flash of result
  localparam int FLASH_FAST_MS  = 500;               // fast flash of result
  // derived cycle counts
  localparam int GAIN_IDLE_CYC  = GAIN_IDLE_MS * CYC_PER_MS;
  localparam int HOLD_CYC       = HOLD_MS * CYC_PER_MS;
  localparam int LISTEN_CYC     = LISTEN_MS * CYC_PER_MS;
  localparam int DTAP_CYC       = DTAP_MS * CYC_PER_MS;
  localparam int SHOW_CYC       = SHOW_MS * CYC_PER_MS;
  localparam int FLASH_SLOW_CYC = FLASH_SLOW_MS * CYC_PER_MS;
  localparam int FLASH_FAST_CYC = FLASH_FAST_MS * CYC_PER_MS;
  localparam int TMR_W          = 28;                // holds 10 s of cycles
  // ring levels: count of lit leds, 0 = off, 9 = max
  localparam int LVL_W     = 4;
  localparam logic [3:0] LVL_MAX   = 4'h9;
  localparam logic [3:0] LVL_UNITY = 4'h5;           // volume unity point
  localparam logic [3:0] LVL_DEF   = 4'h6;           // default vol and gain
  localparam int RING_N    = 9;                      // ring led count
  // blink phase taps of a free counter
  localparam int BLINK_W    = 24;
  localparam int SLOW_BIT   = 23;                    // about 1.5 Hz
  localparam int FAST_BIT   = 21;                    // about 6 Hz
  // register port
  localparam int ADDR_W     = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;         // bit 0: apply defaults
  localparam logic [7:0] REG_STATUS = 8'h04;         // read-only state
  localparam int CTRL_DEF_BIT = 0;
endpackage

// ===== design/knob_gesture.sv
/*
  Press classifier for the push switch of the volume/gain knob: reports a
  single tap, a double tap or a hold as one-cycle pulses.
  Assumes press_in is already synchronised to ref_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module knob_gesture #(
  parameter int HOLD_CYC = knob_pkg::HOLD_CYC,
  parameter int DTAP_CYC = knob_pkg::DTAP_CYC
) (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  input  wire logic press_in,
  output logic      tap1_out,
  output logic      tap2_out,
  output logic      hold_out
);
  import knob_pkg::*;

  // limits must fit the shared counter
  if (HOLD_CYC < 1 || DTAP_CYC < 1 || HOLD_CYC >= (1 << TMR_W) || DTAP_CYC >= (1 << TMR_W))
    $error("knob_gesture: timing out of range");

  localparam logic [TMR_W-1:0] HOLD_LIM = TMR_W'(HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] DTAP_LIM = TMR_W'(DTAP_CYC - 1);

  typedef enum logic [2:0] {G_IDLE, G_PRESS1, G_WAIT, G_PRESS2, G_HELD} g_st_t;
  typedef struct packed {
    g_st_t             st;   // classifier phase
    logic [TMR_W-1:0]  cnt;  // time in phase
    logic              tap1; // single tap pulse
    logic              tap2; // double tap pulse
    logic              hold; // hold pulse
  } g_t;

  g_t q, n;

  // a single tap is only known once the double tap window lapses
  always_comb begin
    n = q;
    n.tap1 = 1'b0;
    n.tap2 = 1'b0;
    n.hold = 1'b0;
    if (ce_in) begin
      n.cnt = q.cnt + 1'b1;
      case (q.st)
        G_IDLE: begin
          if (press_in) begin
            n.st  = G_PRESS1;
            n.cnt = '0;
          end
        end
        G_PRESS1: begin
          if (!press_in) begin
            n.st  = G_WAIT;
            n.cnt = '0;
          end else if (q.cnt >= HOLD_LIM) begin
            n.hold = 1'b1;
            n.st   = G_HELD;
          end
        end
        G_WAIT: begin
          if (press_in) begin
            n.st  = G_PRESS2;
            n.cnt = '0;
          end else if (q.cnt >= DTAP_LIM) begin
            n.tap1 = 1'b1;
            n.st   = G_IDLE;
          end
        end
        G_PRESS2: begin
          if (!press_in) begin
            n.tap2 = 1'b1;
            n.st   = G_IDLE;
          end else if (q.cnt >= HOLD_LIM) begin
            n.hold = 1'b1;
            n.st   = G_HELD;
          end
        end
        G_HELD: begin
          // wait for release so one hold gives one pulse
          if (!press_in) begin
            n.st = G_IDLE;
          end
        end
        default: n.st = G_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tap1_out = q.tap1;
  assign tap2_out = q.tap2;
  assign hold_out = q.hold;
endmodule
`default_nettype wire

// ===== tb/knob_user.sv
/*
  Behavioural user at the knob: push switch and quadrature encoder.
  Assumes the caller runs on clk_in; pins change just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module knob_user (
  input  wire logic clk_in,
  output logic      sw_out,
  output logic      a_out,
  output logic      b_out
);
  // pins idle low, switch released
  initial begin
    sw_out = 1'b0;
    a_out  = 1'b0;
    b_out  = 1'b0;
  end
  // press for n cycles; short n is a tap, long n a hold
  task automatic press(input int n);
    @(posedge clk_in) sw_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    sw_out <= 1'b0;
  endtask
  // one detent per loop; b level at a rise sets the direction
  task automatic turn(input logic up, input int n);
    repeat (n) begin
      @(posedge clk_in) b_out <= !up;
      repeat (4) @(posedge clk_in);
      a_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      a_out <= 1'b0;
      b_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/channel_knob_mode_control_tb.sv
/*
  Self-checking bench: knob gestures, modes, mute, select, auto-gain, port.
  Assumes shortened time parameters; the knob user sits in knob_user.
*/
`timescale 1ns/100ps
`default_nettype none
module channel_knob_mode_control_tb;
  import knob_pkg::*;
  localparam int HOLD = 50;          // shortened hold
  localparam int DT   = 20;          // shortened double tap window
  logic        ref_clk_in;           // 25 MHz
  logic        arst_n_in;
  logic        ce;                   // clock enable, low freezes the block
  logic [4:0]  chan_btn;
  logic [4:0]  clip;
  logic [3:0]  agc;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] q, rdata;
  logic [4:0]  led, mute;
  logic [2:0]  sel;
  logic [19:0] vol, gain;
  logic [8:0]  ring;
  logic        recall, listen, white, red, gind, vgreen, vred;
  logic        sw, ea, eb, recall_seen = 1'b0;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  // sticky record of the recall pulse, one cycle wide
  always @(posedge ref_clk_in) if (recall === 1'b1) recall_seen <= 1'b1;
  knob_user user (.clk_in(ref_clk_in), .sw_out(sw), .a_out(ea), .b_out(eb));
  channel_knob_mode_control #(.GAIN_IDLE_CYC(200), .HOLD_CYC(HOLD),
    .LISTEN_CYC(300), .DTAP_CYC(DT), .SHOW_CYC(20), .FLASH_SLOW_CYC(30),
    .FLASH_FAST_CYC(20)) DUT (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .chan_btn_in(chan_btn), .knob_sw_in(sw), .enc_a_in(ea), .enc_b_in(eb),
    .clip_in(clip), .agc_gain_in(agc), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .chan_led_out(led),
    .sel_chan_out(sel), .recall_out(recall), .vol_all_out(vol),
    .gain_all_out(gain), .mute_out(mute), .agc_listen_out(listen),
    .ring_on_out(ring), .ring_white_out(white), .overload_red_out(red),
    .gain_ind_out(gind), .vol_green_out(vgreen), .vol_red_out(vred));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs about 1500 cycles
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // wait n edges, then step past their updates
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in) wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in) rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic tap();
    user.press(5);
    w(DT + 12);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    // every input starts idle; reset held for 8 edges
    ref_clk_in = 1'b0;
    arst_n_in  = 1'b0;
    ce         = 1'b1;
    chan_btn   = 5'h00;
    clip       = 5'h00;
    agc        = 4'h0;
    addr       = 8'h00;
    wdata      = 32'h0;
    wr         = 1'b0;
    rd         = 1'b0;
    w(8);
    arst_n_in <= 1'b1;
    w(5);
    chk(led, 5'h01);
    chk(vol, 20'h66666);
    chk(gain, 20'h66666);
    chk({vgreen, gind, ring}, {2'b10, 9'h03F});
    done("reset");
    user.turn(1'b0, 6);
    w(4);
    chk(ring, 9'h000);
    user.turn(1'b1, 5);
    w(4);
    chk(ring, 9'h01F);
    user.turn(1'b1, 4);
    w(4);
    chk({white, ring}, {1'b0, 9'h1FF});
    clip <= 5'h1F;
    w(3);
    chk(red, 1'b1);
    clip <= 5'h00;
    done("volume");
    tap();
    chk({gind, white, vgreen, ring}, {3'b110, 9'h03F});
    user.turn(1'b1, 3);
    w(4);
    chk({white, ring, red}, {1'b1, 9'h1FF, 1'b0});
    clip <= 5'h01;
    w(3);
    chk(red, 1'b1);
    clip <= 5'h00;
    w(130);
    user.turn(1'b1, 1);
    w(150);
    chk(gind, 1'b1);
    w(80);
    chk({gind, vgreen}, 2'b01);
    tap();
    tap();
    chk(gind, 1'b0);
    done("gain");
    user.press(5);
    w(5);
    user.press(5);
    w(10);
    chk({mute[0], vred}, 2'b11);
    tap();
    chk({mute[0], vred}, 2'b00);
    done("mute");
    chan_btn <= 5'h10;
    w(6);
    chan_btn <= 5'h00;
    chk({led, sel, recall_seen}, {5'h10, 3'h4, 1'b1});
    chk(vol[3:0], 4'h9);
    rreg(REG_STATUS);
    chk(q[2:0], 3'h4);
    w(1);
    chk(rdata, 32'h0);
    // a turn while the enable is low must leave no step behind
    ce <= 1'b0;
    user.turn(1'b1, 1);
    ce <= 1'b1;
    w(4);
    chk({vol[19:16], ring}, {4'h6, 9'h03F});
    done("select");
    agc <= 4'h3;
    user.press(HOLD + 10);
    w(3);
    chk({listen, gind, gain[19:16]}, {2'b11, 4'h3});
    user.turn(1'b1, 2);
    w(2);
    chk(gain[19:16], 4'h3);
    agc <= 4'h7;
    w(3);
    chk(gain[19:16], 4'h7);
    w(280);
    chk({listen, gain[19:16]}, {1'b0, 4'h7});
    w(100);
    chk({vgreen, white, gind}, 3'b100);
    rreg(REG_STATUS);
    chk({q[9], q[6:4]}, 4'h8);
    done("autogain");
    tap();
    user.turn(1'b1, 1);
    w(4);
    rreg(REG_STATUS);
    chk({q[9], gain[19:16]}, {1'b0, 4'h8});
    user.press(HOLD + 10);
    w(3);
    chk(listen, 1'b1);
    wreg(REG_CTRL, 32'h1);
    w(2);
    chk(vol, 20'h66666);
    chk({gain, listen}, {20'h66666, 1'b0});
    rreg(8'h08);
    chk(q, 32'h0);
    done("registers");
    close_out();
  end
endmodule
`default_nettype wire
